// >>> rwf_pkg.sv
// Purpose: constants shared by the windowed register file and its index mapper
// Assumes: one core clock, 64-bit registers, eight windows, four global sets
// Notes: window count and global set count are fixed implementation values
package rwf_pkg;
   localparam int DATA_W = 64;
   localparam int ADDR_W = 5;
   localparam int N_WIN = 8;
   localparam int CWP_W = 3;
   localparam int CNT_W = 3;
   localparam int MAX_GSET = 3;
   localparam int GL_W = 2;
   localparam int GROUP = 16;
   localparam int WIN_REGS = N_WIN * GROUP;
   localparam int GLOB_REGS = (MAX_GSET + 1) * 8;
   localparam int PHYS_REGS = WIN_REGS + GLOB_REGS;
   localparam int IDX_W = 8;
   localparam logic [ADDR_W-1:0] OUT_BASE = 5'h08;
   localparam logic [ADDR_W-1:0] LOCAL_BASE = 5'h10;
   localparam logic [ADDR_W-1:0] IN_BASE = 5'h18;
   localparam logic [IDX_W-1:0] LOCAL_OFF = 8'h08;
   localparam logic [IDX_W-1:0] OUT_OFF = 8'h10;
   localparam logic [IDX_W-1:0] WIN_REGS_I = 8'h80;
   localparam logic [IDX_W-1:0] GLOB_BASE = 8'h80;
   localparam int CLR_CNT = 16;
   localparam logic [CWP_W-1:0] CWP_LAST = 3'h7;
   localparam logic [CWP_W-1:0] CWP_RST = 3'h0;
   localparam logic [CNT_W-1:0] SAVABLE_RST = 3'h6;
   localparam logic [CNT_W-1:0] RESTORABLE_RST = 3'h0;
   localparam logic [CNT_W-1:0] OTHER_RST = 3'h0;
   typedef enum logic [1:0] {
      RWF_SEL_CWP = 2'h0,
      RWF_SEL_SAVABLE = 2'h1,
      RWF_SEL_RESTORABLE = 2'h3,
      RWF_SEL_OTHER = 2'h2
   } rwf_cnt_sel_t;
endpackage

// >>> rwf_index_map.sv
// Purpose: map a visible register address to a physical register index
// Assumes: window pointer already within range
// Notes: purely combinational
`timescale 1ns/10ps
module rwf_index_map
   import rwf_pkg::*;
(
   input wire logic [rwf_pkg::CWP_W-1:0] cwp_i,
   input wire logic [rwf_pkg::ADDR_W-1:0] addr_i,
   input wire logic [rwf_pkg::GL_W-1:0] gl_i,
   output logic [rwf_pkg::IDX_W-1:0] idx_o,
   output logic zero_o
);
   logic [IDX_W-1:0] off;
   logic [IDX_W-1:0] sum;
   logic [IDX_W-1:0] addr_w;

   always_comb begin
      addr_w = {3'h0, addr_i};
      off = 8'h00;
      sum = 8'h00;
      zero_o = (addr_i == 5'h00);
      if (addr_i < OUT_BASE) begin
         // selected global set
         idx_o = GLOB_BASE + {3'h0, gl_i, 3'h0} + addr_w;
      end else begin
         if (addr_i >= IN_BASE) begin
            off = addr_w - {3'h0, IN_BASE};
         end else if (addr_i >= LOCAL_BASE) begin
            off = addr_w - {3'h0, LOCAL_BASE} + LOCAL_OFF;
         end else begin
            // outs land in the next group's ins
            off = addr_w - {3'h0, OUT_BASE} + OUT_OFF;
         end
         sum = {1'b0, cwp_i, 4'h0} + off;
         if (sum >= WIN_REGS_I) begin
            idx_o = sum - WIN_REGS_I;
         end else begin
            idx_o = sum;
         end
      end
   end
endmodule

// >>> rwf_register_window_file.sv
// Purpose: windowed integer register file with window pointer and counters
// Assumes: at most one window operation per cycle from the pipeline
// Notes: read data is registered, one cycle after the address
`timescale 1ns/10ps
module rwf_register_window_file
   import rwf_pkg::*;
(
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic [rwf_pkg::ADDR_W-1:0] rd_a_addr_i,
   input wire logic [rwf_pkg::ADDR_W-1:0] rd_b_addr_i,
   output logic [rwf_pkg::DATA_W-1:0] rd_a_data_o,
   output logic [rwf_pkg::DATA_W-1:0] rd_b_data_o,
   input wire logic wr_en_i,
   input wire logic [rwf_pkg::ADDR_W-1:0] wr_addr_i,
   input wire logic [rwf_pkg::DATA_W-1:0] wr_data_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic spill_complete_op_i,
   input wire logic fill_complete_op_i,
   input wire logic jump_and_link_op_i,
   input wire logic cnt_wr_en_i,
   input wire rwf_pkg::rwf_cnt_sel_t cnt_wr_sel_i,
   input wire logic [rwf_pkg::CNT_W-1:0] cnt_wr_data_i,
   input wire logic [rwf_pkg::GL_W-1:0] global_level_select_i,
   output logic [rwf_pkg::CWP_W-1:0] current_window_pointer_o,
   output logic [rwf_pkg::CNT_W-1:0] savable_window_count_o,
   output logic [rwf_pkg::CNT_W-1:0] restorable_window_count_o,
   output logic [rwf_pkg::CNT_W-1:0] other_window_count_o,
   output logic spill_trap_o,
   output logic fill_trap_o,
   output logic op_done_o
);
   // storage
   logic [DATA_W-1:0] regs_q [0:PHYS_REGS-1];
   logic [WIN_REGS-1:0] valid_q;
   logic [WIN_REGS-1:0] valid_d;

   // window state
   logic [CWP_W-1:0] cwp_q;
   logic [CWP_W-1:0] cwp_d;
   logic [CNT_W-1:0] sav_q;
   logic [CNT_W-1:0] sav_d;
   logic [CNT_W-1:0] res_q;
   logic [CNT_W-1:0] res_d;
   logic [CNT_W-1:0] oth_q;
   logic [CNT_W-1:0] oth_d;
   logic spill_q;
   logic spill_d;
   logic fill_q;
   logic fill_d;
   logic done_q;
   logic done_d;
   logic push_ok;

   // read outputs
   logic [DATA_W-1:0] rda_q;
   logic [DATA_W-1:0] rda_d;
   logic [DATA_W-1:0] rdb_q;
   logic [DATA_W-1:0] rdb_d;

   // mapped indices
   logic [IDX_W-1:0] rda_idx;
   logic [IDX_W-1:0] rdb_idx;
   logic [IDX_W-1:0] wr_idx;
   logic rda_zero;
   logic rdb_zero;
   logic wr_zero;
   logic wr_live;

   // decoded window op, at most one per cycle
   logic op_push;
   logic op_pop;
   logic op_sc;
   logic op_fc;
   logic op_jal;
   logic op_load;

   rwf_index_map u_map_rda (
      .cwp_i(cwp_q),
      .addr_i(rd_a_addr_i),
      .gl_i(global_level_select_i),
      .idx_o(rda_idx),
      .zero_o(rda_zero)
   );

   rwf_index_map u_map_rdb (
      .cwp_i(cwp_q),
      .addr_i(rd_b_addr_i),
      .gl_i(global_level_select_i),
      .idx_o(rdb_idx),
      .zero_o(rdb_zero)
   );

   rwf_index_map u_map_wr (
      .cwp_i(cwp_q),
      .addr_i(wr_addr_i),
      .gl_i(global_level_select_i),
      .idx_o(wr_idx),
      .zero_o(wr_zero)
   );

   // wrapping pointer steps
   function automatic logic [CWP_W-1:0] cwp_inc(input logic [CWP_W-1:0] p);
      cwp_inc = (p == CWP_LAST) ? CWP_RST : p + 3'h1;
   endfunction

   function automatic logic [CWP_W-1:0] cwp_dec(input logic [CWP_W-1:0] p);
      cwp_dec = (p == CWP_RST) ? CWP_LAST : p - 3'h1;
   endfunction

   // one read port with zero, clean and bypass handling
   function automatic logic [DATA_W-1:0] rd_value(
      input logic [IDX_W-1:0] idx,
      input logic zero,
      input logic [DATA_W-1:0] stored,
      input logic vld
   );
      rd_value = stored;
      if (zero) begin
         rd_value = '0;
      end else if (wr_live && (wr_idx == idx)) begin
         rd_value = wr_data_i;
      end else if ((idx < WIN_REGS_I) && !vld) begin
         rd_value = '0;
      end
   endfunction

   assign wr_live = wr_en_i && !wr_zero;

   // highest priority op wins, lower ones dropped
   always_comb begin
      op_push = 1'b0;
      op_pop = 1'b0;
      op_sc = 1'b0;
      op_fc = 1'b0;
      op_jal = 1'b0;
      op_load = 1'b0;
      if (push_i) begin
         op_push = 1'b1;
      end else if (pop_i) begin
         op_pop = 1'b1;
      end else if (spill_complete_op_i) begin
         op_sc = 1'b1;
      end else if (fill_complete_op_i) begin
         op_fc = 1'b1;
      end else if (jump_and_link_op_i) begin
         op_jal = 1'b1;
      end else if (cnt_wr_en_i) begin
         op_load = 1'b1;
      end
   end

   // window pointer and counters
   always_comb begin
      cwp_d = cwp_q;
      sav_d = sav_q;
      res_d = res_q;
      oth_d = oth_q;
      spill_d = 1'b0;
      fill_d = 1'b0;
      done_d = 1'b0;
      push_ok = 1'b0;
      if (op_push) begin
         if (sav_q == 3'h0) begin
            // overlap window would be entered
            spill_d = 1'b1;
         end else begin
            push_ok = 1'b1;
            cwp_d = cwp_inc(cwp_q);
            sav_d = sav_q - 3'h1;
            res_d = res_q + 3'h1;
            done_d = 1'b1;
         end
      end else if (op_pop) begin
         if (res_q == 3'h0) begin
            fill_d = 1'b1;
         end else begin
            cwp_d = cwp_dec(cwp_q);
            res_d = res_q - 3'h1;
            sav_d = sav_q + 3'h1;
            done_d = 1'b1;
         end
      end else if (op_sc) begin
         sav_d = sav_q + 3'h1;
         if (oth_q == 3'h0) begin
            res_d = res_q - 3'h1;
         end else begin
            oth_d = oth_q - 3'h1;
         end
         done_d = 1'b1;
      end else if (op_fc) begin
         res_d = res_q + 3'h1;
         if (oth_q == 3'h0) begin
            sav_d = sav_q - 3'h1;
         end else begin
            oth_d = oth_q - 3'h1;
         end
         done_d = 1'b1;
      end else if (op_jal) begin
         // call keeps the current window
         cwp_d = cwp_q;
         done_d = 1'b1;
      end else if (op_load) begin
         unique case (cnt_wr_sel_i)
            RWF_SEL_CWP: begin
               if (cnt_wr_data_i <= CWP_LAST) begin
                  cwp_d = cnt_wr_data_i;
               end
            end
            RWF_SEL_SAVABLE: begin
               sav_d = cnt_wr_data_i;
            end
            RWF_SEL_RESTORABLE: begin
               res_d = cnt_wr_data_i;
            end
            RWF_SEL_OTHER: begin
               oth_d = cnt_wr_data_i;
            end
         endcase
         done_d = 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         cwp_q <= CWP_RST;
         sav_q <= SAVABLE_RST;
         res_q <= RESTORABLE_RST;
         oth_q <= OTHER_RST;
         spill_q <= 1'b0;
         fill_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         cwp_q <= cwp_d;
         sav_q <= sav_d;
         res_q <= res_d;
         oth_q <= oth_d;
         spill_q <= spill_d;
         fill_q <= fill_d;
         done_q <= done_d;
      end
   end

   // clean marks for windowed registers
   always_comb begin
      logic [IDX_W-1:0] base;
      logic [IDX_W-1:0] cidx;
      base = {1'b0, cwp_inc(cwp_q), 4'h0} + LOCAL_OFF;
      cidx = 8'h00;
      valid_d = valid_q;
      if (push_ok) begin
         // new locals and outs read zero until written
         for (int k = 0; k < CLR_CNT; k++) begin
            cidx = base + 8'(k);
            if (cidx >= WIN_REGS_I) begin
               cidx = cidx - WIN_REGS_I;
            end
            valid_d[cidx[6:0]] = 1'b0;
         end
      end
      if (wr_live && (wr_idx < WIN_REGS_I)) begin
         valid_d[wr_idx[6:0]] = 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         valid_q <= '0;
      end else begin
         valid_q <= valid_d;
      end
   end

   // data array, not reset
   always_ff @(posedge clock_i) begin
      if (wr_live) begin
         regs_q[wr_idx] <= wr_data_i;
      end
   end

   // registered read ports
   always_comb begin
      rda_d = rd_value(rda_idx, rda_zero, regs_q[rda_idx],
         (rda_idx < WIN_REGS_I) ? valid_q[rda_idx[6:0]] : 1'b1);
      rdb_d = rd_value(rdb_idx, rdb_zero, regs_q[rdb_idx],
         (rdb_idx < WIN_REGS_I) ? valid_q[rdb_idx[6:0]] : 1'b1);
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         rda_q <= '0;
         rdb_q <= '0;
      end else begin
         rda_q <= rda_d;
         rdb_q <= rdb_d;
      end
   end

   assign rd_a_data_o = rda_q;
   assign rd_b_data_o = rdb_q;
   assign current_window_pointer_o = cwp_q;
   assign savable_window_count_o = sav_q;
   assign restorable_window_count_o = res_q;
   assign other_window_count_o = oth_q;
   assign spill_trap_o = spill_q;
   assign fill_trap_o = fill_q;
   assign op_done_o = done_q;
endmodule

// >>> rwf_properties.sv
// Purpose: port properties of the windowed register file
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the design top
`timescale 1ns/10ps
module rwf_properties
   import rwf_pkg::*;
(
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic [4:0] rd_a_addr_i,
   input wire logic [63:0] rd_a_data_o,
   input wire logic wr_en_i,
   input wire logic [4:0] wr_addr_i,
   input wire logic [63:0] wr_data_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic spill_complete_op_i,
   input wire logic fill_complete_op_i,
   input wire logic jump_and_link_op_i,
   input wire logic [2:0] current_window_pointer_o,
   input wire logic [2:0] savable_window_count_o,
   input wire logic [2:0] restorable_window_count_o,
   input wire logic [2:0] other_window_count_o,
   input wire logic spill_trap_o,
   input wire logic fill_trap_o,
   input wire logic op_done_o
);
   logic [2:0] current_window_pointer, sav, res, sum;
   logic hi;
   assign current_window_pointer = current_window_pointer_o;
   assign sav = savable_window_count_o;
   assign res = restorable_window_count_o;
   assign sum = sav + res + other_window_count_o;
   assign hi = push_i | pop_i | spill_complete_op_i | fill_complete_op_i;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   sequence s_took;
      ##1 op_done_o;
   endsequence
   property p_push;
      push_i && sav != 3'h0 |-> s_took ##0 (current_window_pointer == $past(current_window_pointer) + 3'h1 && sum == $past(sum));
   endproperty
   a_push: assert property (p_push) else $error("push");
   property p_pop;
      pop_i && !push_i && res != 3'h0 |-> s_took ##0 (current_window_pointer == $past(current_window_pointer) - 3'h1);
   endproperty
   a_pop: assert property (p_pop) else $error("pop");
   property p_spill;
      push_i && sav == 3'h0 |=> spill_trap_o && !op_done_o && $stable(current_window_pointer);
   endproperty
   a_spill: assert property (p_spill) else $error("spill");
   property p_fill;
      pop_i && !push_i && res == 3'h0 |=> fill_trap_o && $stable(current_window_pointer);
   endproperty
   a_fill: assert property (p_fill) else $error("fill");
   property p_sc;
      spill_complete_op_i && !push_i && !pop_i |=> sav == $past(sav) + 3'h1;
   endproperty
   a_sc: assert property (p_sc) else $error("spill complete");
   property p_fc;
      fill_complete_op_i && !push_i && !pop_i && !spill_complete_op_i |=> res == $past(res) + 3'h1;
   endproperty
   a_fc: assert property (p_fc) else $error("fill complete");
   property p_jal;
      jump_and_link_op_i && !hi |-> s_took ##0 $stable(current_window_pointer);
   endproperty
   a_jal: assert property (p_jal) else $error("call");
   property p_zero;
      rd_a_addr_i == 5'h00 |=> rd_a_data_o == 64'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("zero");
   property p_byp;
      wr_en_i && wr_addr_i != 5'h00 && wr_addr_i == rd_a_addr_i |=> rd_a_data_o == $past(wr_data_i);
   endproperty
   a_byp: assert property (p_byp) else $error("bypass");
endmodule
bind rwf_register_window_file rwf_properties i_rwf_properties (.clock_i, .resetn_i,
   .rd_a_addr_i, .rd_a_data_o, .wr_en_i, .wr_addr_i, .wr_data_i, .push_i, .pop_i,
   .spill_complete_op_i, .fill_complete_op_i, .jump_and_link_op_i, .current_window_pointer_o,
   .savable_window_count_o, .restorable_window_count_o, .other_window_count_o,
   .spill_trap_o, .fill_trap_o, .op_done_o);

// >>> rwf_pipe_model.sv
// Purpose: pipeline stand-in issuing window ops
// Assumes: command changes at the falling edge
// Notes: at most one op per cycle
`timescale 1ns/10ps
module rwf_pipe_model (
   input wire logic [2:0] cmd_i,
   output logic push_o,
   output logic pop_o,
   output logic spill_o,
   output logic fill_o,
   output logic jal_o,
   output logic load_o
);
   // one command, one op pulse
   assign push_o = cmd_i == 3'h1;
   assign pop_o = cmd_i == 3'h2;
   assign spill_o = cmd_i == 3'h3;
   assign fill_o = cmd_i == 3'h4;
   assign jal_o = cmd_i == 3'h5;
   assign load_o = cmd_i == 3'h6;
endmodule

// >>> testbench.sv
// Purpose: self-checking bench of the windowed register file
// Assumes: inputs driven at the falling edge
// Notes: random data from a fixed-seed xorshift
`timescale 1ns/10ps
module testbench;
   import rwf_pkg::*;
   logic clock_i = 1'b0, resetn_i = 1'b0, we = 1'b0;
   logic [4:0] ra = 5'h00, wa = 5'h00, a;
   logic [63:0] wd = 64'h0, rda, rdb, v;
   logic [63:0] d [8];
   logic [2:0] cmd = 3'h0, cd = 3'h0, current_window_pointer, sav, res, oth;
   logic [1:0] gl = 2'h0;
   rwf_cnt_sel_t sel = RWF_SEL_CWP;
   logic push, pop, sc, fc, jal, ld, st, ft, done;
   logic [31:0] seed = 32'hbde5;
   int n_fail = 0, compares = 0, cyc = 0;
   rwf_pipe_model i_rwf_pipe_model (.cmd_i(cmd), .push_o(push), .pop_o(pop), .spill_o(sc),
      .fill_o(fc), .jal_o(jal), .load_o(ld));
   rwf_register_window_file i_rwf_register_window_file (.clock_i, .resetn_i,
      .rd_a_addr_i(ra), .rd_b_addr_i(ra), .rd_a_data_o(rda), .rd_b_data_o(rdb),
      .wr_en_i(we), .wr_addr_i(wa), .wr_data_i(wd), .push_i(push), .pop_i(pop),
      .spill_complete_op_i(sc), .fill_complete_op_i(fc), .jump_and_link_op_i(jal),
      .cnt_wr_en_i(ld), .cnt_wr_sel_i(sel), .cnt_wr_data_i(cd),
      .global_level_select_i(gl), .current_window_pointer_o(current_window_pointer),
      .savable_window_count_o(sav), .restorable_window_count_o(res),
      .other_window_count_o(oth), .spill_trap_o(st), .fill_trap_o(ft), .op_done_o(done));
   initial begin
      forever #2 clock_i = ~clock_i;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [2:0] nxt(input logic [2:0] c, input logic up);
      return up ? c + 3'h1 : c - 3'h1;
   endfunction
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] e);
      compares++;
      if (seen !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, seen);
      end
   endtask
   task automatic close_out();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [4:0] x, input logic [63:0] y);
      @(negedge clock_i);
      we = 1'b1;
      wa = x;
      ra = x;
      wd = y;
      @(negedge clock_i);
      we = 1'b0;
   endtask
   task automatic rd(input logic [4:0] x, input logic [63:0] e);
      @(negedge clock_i);
      ra = x;
      @(negedge clock_i);
      chk("rd_a_data_o", rda, e);
      chk("rd_b_data_o", rdb, e);
   endtask
   task automatic op(input logic [2:0] c);
      @(negedge clock_i);
      cmd = c;
      @(negedge clock_i);
      cmd = 3'h0;
   endtask
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end
   initial begin
      repeat (16) @(negedge clock_i);
      resetn_i = 1'b1;
      chk("pointer", current_window_pointer, 0);
      chk("sum", sav + res + oth, 6);
      for (int k = 0; k < 8; k++) begin
         d[k] = {xs(), xs()};
         wr(5'(8 + k), d[k]);
      end
      v = {xs(), xs()};
      wr(5'h10, v);
      op(3'h1);
      chk("done", done, 1);
      chk("pointer", current_window_pointer, 1);
      for (int k = 0; k < 8; k++) rd(5'(24 + k), d[k]);
      rd(5'h10, 0);
      rd(5'h0f, 0);
      for (int k = 0; k < 8; k++) begin
         d[k] = {xs(), xs()};
         wr(5'(24 + k), d[k]);
      end
      op(3'h2);
      chk("pointer", current_window_pointer, 0);
      for (int k = 0; k < 8; k++) rd(5'(8 + k), d[k]);
      rd(5'h10, v);
      for (int k = 1; k < 7; k++) begin
         op(3'h1);
         chk("pointer", current_window_pointer, nxt(3'(k - 1), 1'b1));
      end
      op(3'h1);
      chk("spill", st, 1);
      chk("pointer", current_window_pointer, 6);
      for (int k = 0; k < 6; k++) op(3'h2);
      op(3'h2);
      chk("fill", ft, 1);
      chk("pointer", current_window_pointer, 0);
      cd = 3'h7;
      op(3'h6);
      chk("pointer", current_window_pointer, 7);
      v = {xs(), xs()};
      wr(5'h08, v);
      op(3'h1);
      chk("pointer", current_window_pointer, nxt(3'h7, 1'b1));
      rd(5'h18, v);
      op(3'h3);
      chk("restorable", res, 0);
      op(3'h4);
      chk("savable", sav, 5);
      op(3'h5);
      chk("pointer", current_window_pointer, 0);
      sel = RWF_SEL_SAVABLE;
      cd = 3'h3;
      op(3'h6);
      chk("savable", sav, 3);
      sel = RWF_SEL_OTHER;
      cd = 3'h2;
      op(3'h6);
      chk("other", oth, 2);
      op(3'h3);
      chk("savable", sav, 4);
      chk("other", oth, 1);
      op(3'h4);
      chk("restorable", res, 2);
      chk("other", oth, 0);
      chk("sum", sav + res + oth, 6);
      for (int g = 0; g < 4; g++) begin
         gl = 2'(g);
         d[g] = {xs(), xs()};
         wr(5'h01, d[g]);
      end
      for (int g = 0; g < 4; g++) begin
         gl = 2'(g);
         rd(5'h01, d[g]);
      end
      wr(5'h00, v);
      rd(5'h00, 0);
      for (int k = 0; k < 24; k++) begin
         a = 5'(8 + xs() % 24);
         v = {xs(), xs()};
         wr(a, v);
         rd(a, v);
      end
      close_out();
   end
endmodule
